// ---- wdt_pkg.sv ----
// Shared constants and types of the watchdog with reset flags
package wdt_pkg;

   ////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] CTRL_OFFSET   = 8'h60;
   localparam logic [7:0] STATUS_OFFSET = 8'h64;

   ////////////////////////////////////////////////////////////////
   // Control fields
   localparam int IRQ_FLAG_BIT = 7;
   localparam int IRQ_EN_BIT   = 6;
   localparam int PSC3_BIT     = 5;
   localparam int CE_BIT       = 4;
   localparam int WDE_BIT      = 3;
   localparam int PSC_LOW_MSB  = 2;

   ////////////////////////////////////////////////////////////////
   // Status fields
   localparam int DOG_BIT = 3;
   localparam int BOR_BIT = 2;
   localparam int PIN_BIT = 1;
   localparam int POR_BIT = 0;

   ////////////////////////////////////////////////////////////////
   // Reset values and counts
   localparam logic [7:0]  CTRL_RESET         = 8'h00;
   localparam logic [3:0]  STATUS_POR_RESET   = 4'h1;
   localparam logic [1:0]  FUSE_SYNC_RESET    = 2'h3;
   localparam logic [2:0]  CE_WINDOW_CYCLES   = 3'h4;
   localparam int unsigned BASE_TIMEOUT_TICKS = 2048;
   localparam logic [3:0]  PRESCALE_MAX       = 4'h9;

   ////////////////////////////////////////////////////////////////
   // Bus answers and modes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {MODE_STOP, MODE_IRQ, MODE_RESET, MODE_BOTH} mode_t;

endpackage

// ---- wdt_count_if.sv ----
// Link between control logic and time-out counter
`timescale 1ns/100ps
interface wdt_count_if;
   logic       osc_tick;
   logic       restart;
   logic [3:0] prescale;
   logic       timeout;

   modport ctrl    (output osc_tick, output restart, output prescale, input timeout);
   modport counter (input osc_tick, input restart, input prescale, output timeout);
endinterface

// ---- wdt_counter.sv ----
// Time-out counter stepped by oscillator ticks
`timescale 1ns/100ps
module wdt_counter #(
   parameter int unsigned base_ticks = wdt_pkg::BASE_TIMEOUT_TICKS
) (
   input wire logic      clk,
   input wire logic      resetn,
   wdt_count_if.counter  cnt
);
   import wdt_pkg::*;

   typedef struct packed {
      logic [20:0] count;
      logic        timeout;
   } cnt_state_t;

   cnt_state_t  s;
   cnt_state_t  next_s;
   logic [3:0]  sel;
   logic [31:0] span;
   logic [20:0] limit;

   ////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s = s;
      next_s.timeout = 1'b0;
      // Reserved codes take the longest period
      sel = (cnt.prescale > PRESCALE_MAX) ? PRESCALE_MAX : cnt.prescale;
      span = 32'(base_ticks) << sel;
      limit = 21'(span - 32'h1);
      if (cnt.restart) begin
         next_s.count = '0;
      end else if (cnt.osc_tick) begin
         // Shorter period may expire at once
         if (s.count >= limit) begin
            next_s.count = '0;
            next_s.timeout = 1'b1;
         end else begin
            next_s.count = s.count + 21'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign cnt.timeout = s.timeout;

   ////////////////////////////////////////////////////////////////
   // Checks
   AST_RESTART_ZERO: assert property (@(posedge clk) disable iff (!resetn)
      cnt.restart |=> (s.count == 21'h0) && !s.timeout)
      else $error("restart did not clear the counter");

endmodule // wdt_counter

// ---- watchdog_with_reset_flags.sv ----
// Watchdog timer with reset-source flags and register slave
//
// Function
// - Status bits 7..4 read zero
// - Watchdog reset sets bit 3, zero-write clears
// - Brown-out reset sets bit 2, zero-write clears
// - Pin reset sets bit 1, zero-write clears
// - Power-on sets bit 0, only zero-write clears
// - Time-out flag set; vector or one-write clears
// - Interrupt when flag, enable, global enable set
// - Combined mode vector clears enable and flag
// - Unserviced second time-out gives system reset
// - Enable bits pick stop, irq, reset, both
// - Programmed fuse forces system reset mode
// - Protected changes need change enable set
// - Change enable clears four cycles after set
// - Reset enable forced while watchdog flag set
// - Counter steps on separate slow oscillator
// - Restart instruction clears counter to zero
// - Reset request lasts one system cycle
`timescale 1ns/100ps
module watchdog_with_reset_flags #(
   parameter int unsigned base_ticks = wdt_pkg::BASE_TIMEOUT_TICKS
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output wire logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output wire logic        wready,
   output wire logic [1:0]  bresp,
   output wire logic        bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output wire logic        arready,
   output wire logic [31:0] rdata,
   output wire logic [1:0]  rresp,
   output wire logic        rvalid,
   input  wire logic        rready,
   input  wire logic        wdt_osc,
   input  wire logic        always_on_fuse,
   input  wire logic        brownout_reset,
   input  wire logic        pin_reset,
   input  wire logic        dog_restart,
   input  wire logic        cpu_irq_enable,
   input  wire logic        irq_ack,
   output wire logic        irq,
   output wire logic        sys_reset_req
);
   import wdt_pkg::*;

   ////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic       awready;
      logic [7:0] awaddr;
      logic       wready;
      logic [7:0] wdata;
      logic       wstrb0;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ctrl;
      logic [2:0] ce_cnt;
      logic [3:0] flags;
      logic [2:0] osc_s;
      logic [1:0] fuse_s;
      logic [1:0] bor_s;
      logic [1:0] pin_s;
      logic       irq;
      logic       sys_reset;
   } state_t;

   localparam state_t STATE_RESET = '{
      awready : 1'b1,
      wready  : 1'b1,
      arready : 1'b1,
      ctrl    : CTRL_RESET,
      flags   : STATUS_POR_RESET,
      fuse_s  : FUSE_SYNC_RESET,
      default : '0
   };

   state_t      s;
   state_t      next_s;
   mode_t       mode;
   logic        fuse_prog;
   logic        wde_eff;
   logic        ie_eff;
   logic        sys_evt;
   logic        timeout_ev;
   logic        flag_set;
   logic        reset_now;
   logic        wr_fire;
   logic        wr_ctrl;
   logic        wr_stat;
   logic        unlock;
   logic [7:0]  wd;
   logic [7:0]  ctrl_rd;

   wdt_count_if cnt ();

   wdt_counter #(
      .base_ticks (base_ticks)
   ) u_counter (
      .clk    (clk),
      .resetn (resetn),
      .cnt    (cnt)
   );

   ////////////////////////////////////////////////////////////////
   // Counter hookup
   assign cnt.osc_tick = s.osc_s[1] & !s.osc_s[2];
   assign cnt.restart  = dog_restart | (mode == MODE_STOP) | sys_evt;
   assign cnt.prescale = {s.ctrl[PSC3_BIT], s.ctrl[PSC_LOW_MSB:0]};
   assign timeout_ev   = cnt.timeout;

   ////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s = s;

      // Two-stage synchronisers
      next_s.osc_s  = {s.osc_s[1:0], wdt_osc};
      next_s.fuse_s = {s.fuse_s[0], always_on_fuse};
      next_s.bor_s  = {s.bor_s[0], brownout_reset};
      next_s.pin_s  = {s.pin_s[0], pin_reset};

      // Mode decode
      fuse_prog = !s.fuse_s[1];
      wde_eff = s.ctrl[WDE_BIT] | fuse_prog;
      ie_eff = s.ctrl[IRQ_EN_BIT] & !fuse_prog;
      case ({wde_eff, ie_eff})
         2'h1: mode = MODE_IRQ;
         2'h2: mode = MODE_RESET;
         2'h3: mode = MODE_BOTH;
         default: mode = MODE_STOP;
      endcase
      sys_evt = s.sys_reset | s.bor_s[1] | s.pin_s[1];

      // Time-out action
      flag_set = timeout_ev & ((mode == MODE_IRQ) |
                 ((mode == MODE_BOTH) & !s.ctrl[IRQ_FLAG_BIT]));
      reset_now = timeout_ev & ((mode == MODE_RESET) |
                  ((mode == MODE_BOTH) & s.ctrl[IRQ_FLAG_BIT]));

      // Write channels
      wd = s.wdata;
      wr_fire = !s.awready & !s.wready & !s.bvalid;
      wr_ctrl = wr_fire & s.wstrb0 & (s.awaddr == CTRL_OFFSET);
      wr_stat = wr_fire & s.wstrb0 & (s.awaddr == STATUS_OFFSET);
      unlock = wd[CE_BIT] & wd[WDE_BIT];
      if (awvalid & s.awready) begin
         next_s.awready = 1'b0;
         next_s.awaddr = awaddr;
      end
      if (wvalid & s.wready) begin
         next_s.wready = 1'b0;
         next_s.wdata = wdata[7:0];
         next_s.wstrb0 = wstrb[0];
      end
      if (wr_fire) begin
         next_s.bvalid = 1'b1;
         if ((s.awaddr == CTRL_OFFSET) | (s.awaddr == STATUS_OFFSET)) begin
            next_s.bresp = RESP_OKAY;
         end else begin
            next_s.bresp = RESP_DECERR;
         end
      end
      if (s.bvalid & bready) begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end

      // Read channels
      ctrl_rd = s.ctrl;
      ctrl_rd[WDE_BIT] = wde_eff;
      ctrl_rd[IRQ_EN_BIT] = ie_eff;
      if (arvalid & s.arready) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         case (araddr)
            CTRL_OFFSET: next_s.rdata = ctrl_rd;
            STATUS_OFFSET: next_s.rdata = {4'h0, s.flags};
            default: begin
               next_s.rdata = 8'h00;
               next_s.rresp = RESP_DECERR;
            end
         endcase
      end
      if (s.rvalid & rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end

      // Change window countdown
      if (s.ctrl[CE_BIT]) begin
         next_s.ce_cnt = s.ce_cnt - 3'h1;
         if (s.ce_cnt == 3'h1) begin
            next_s.ctrl[CE_BIT] = 1'b0;
         end
      end

      // Control register write
      if (wr_ctrl) begin
         if (wd[IRQ_FLAG_BIT]) begin
            next_s.ctrl[IRQ_FLAG_BIT] = 1'b0;
         end
         next_s.ctrl[IRQ_EN_BIT] = wd[IRQ_EN_BIT];
         if (s.ctrl[CE_BIT]) begin
            next_s.ctrl[WDE_BIT] = wd[WDE_BIT];
            next_s.ctrl[PSC3_BIT] = wd[PSC3_BIT];
            next_s.ctrl[PSC_LOW_MSB:0] = wd[PSC_LOW_MSB:0];
         end else begin
            next_s.ctrl[WDE_BIT] = s.ctrl[WDE_BIT] | wd[WDE_BIT];
         end
         next_s.ctrl[CE_BIT] = unlock;
         if (unlock) begin
            next_s.ce_cnt = CE_WINDOW_CYCLES;
         end
      end

      // Vector taken
      if (irq_ack) begin
         next_s.ctrl[IRQ_FLAG_BIT] = 1'b0;
         if (wde_eff) begin
            next_s.ctrl[IRQ_EN_BIT] = 1'b0;
         end
      end

      // Status register write
      if (wr_stat) begin
         next_s.flags = s.flags & wd[3:0];
      end

      // System reset returns control to defaults
      if (sys_evt) begin
         next_s.ctrl = CTRL_RESET;
      end

      // Hardware sets win over clears
      if (flag_set) begin
         next_s.ctrl[IRQ_FLAG_BIT] = 1'b1;
      end
      next_s.flags[DOG_BIT] = next_s.flags[DOG_BIT] | reset_now;
      next_s.flags[BOR_BIT] = next_s.flags[BOR_BIT] | s.bor_s[1];
      next_s.flags[PIN_BIT] = next_s.flags[PIN_BIT] | s.pin_s[1];
      next_s.ctrl[WDE_BIT] = next_s.ctrl[WDE_BIT] | next_s.flags[DOG_BIT];

      // Outputs
      next_s.sys_reset = reset_now;
      next_s.irq = next_s.ctrl[IRQ_FLAG_BIT] & next_s.ctrl[IRQ_EN_BIT] &
                   !fuse_prog & cpu_irq_enable;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Ports
   assign awready       = s.awready;
   assign wready        = s.wready;
   assign bvalid        = s.bvalid;
   assign bresp         = s.bresp;
   assign arready       = s.arready;
   assign rvalid        = s.rvalid;
   assign rresp         = s.rresp;
   assign rdata         = {24'h000000, s.rdata};
   assign irq           = s.irq;
   assign sys_reset_req = s.sys_reset;

   ////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   AST_STATUS_HIGH_ZERO: assert property (
      (arvalid && arready && araddr == STATUS_OFFSET) |=> rdata[7:4] == 4'h0)
      else $error("status upper bits not zero");

   AST_DOG_FLAG_SET: assert property (
      $rose(sys_reset_req) |-> s.flags[DOG_BIT])
      else $error("watchdog reset without flag");

   AST_BOR_FLAG_SET: assert property (
      s.bor_s[1] |=> s.flags[BOR_BIT])
      else $error("brown-out flag not set");

   AST_PIN_FLAG_SET: assert property (
      s.pin_s[1] |=> s.flags[PIN_BIT])
      else $error("pin reset flag not set");

   AST_POR_ONLY_WRITE: assert property (
      $fell(s.flags[POR_BIT]) |-> $past(wr_stat) && !$past(s.wdata[POR_BIT]))
      else $error("power-on flag cleared without write");

   AST_ACK_CLEARS: assert property (
      (irq_ack && mode == MODE_BOTH && !timeout_ev && !wr_ctrl) |=>
      !s.ctrl[IRQ_FLAG_BIT] && !s.ctrl[IRQ_EN_BIT])
      else $error("vector did not leave combined mode");

   AST_IRQ_NEEDS_FLAG: assert property (
      irq |-> s.ctrl[IRQ_FLAG_BIT] && s.ctrl[IRQ_EN_BIT] && s.fuse_s[1])
      else $error("interrupt without flag and enable");

   AST_UNSERVICED_RESET: assert property (
      (timeout_ev && mode == MODE_BOTH && s.ctrl[IRQ_FLAG_BIT]) |=> sys_reset_req)
      else $error("second time-out gave no reset");

   AST_FUSE_RESET: assert property (
      (timeout_ev && !s.fuse_s[1]) |=> sys_reset_req)
      else $error("fuse mode time-out gave no reset");

   AST_CE_WINDOW: assert property (
      ($rose(s.ctrl[CE_BIT]) && !wr_ctrl) ##1 !wr_ctrl [*3] |=> !s.ctrl[CE_BIT])
      else $error("change enable not closed after four cycles");

   AST_WDE_FORCED: assert property (
      s.flags[DOG_BIT] |-> s.ctrl[WDE_BIT])
      else $error("reset enable not forced");

   AST_RESET_PULSE: assert property (
      sys_reset_req |=> !sys_reset_req)
      else $error("reset request longer than one cycle");

   AST_LOCKED_PRESCALE: assert property (
      (wr_ctrl && !s.ctrl[CE_BIT] && !sys_evt) |=> $stable(cnt.prescale))
      else $error("prescale changed without change enable");

   COV_IRQ_MODE: cover property (flag_set && mode == MODE_IRQ);
   COV_BOTH_RESET: cover property (timeout_ev && mode == MODE_BOTH ##1 sys_reset_req);
   COV_UNLOCK_CHANGE: cover property (wr_ctrl && s.ctrl[CE_BIT]);

endmodule // watchdog_with_reset_flags

// ---- tb.sv ----
// Self-checking testbench of the watchdog with reset flags
`timescale 1ns/100ps
module tb;
   import wdt_pkg::*;
   logic             clk, resetn, awvalid, wvalid, bready, arvalid, rready, wdt_osc;
   logic             always_on_fuse, brownout_reset, pin_reset, dog_restart, cpu_irq_enable, irq_ack;
   logic [7:0]       awaddr, araddr;
   logic [31:0]      wdata, rdv, seed;
   logic [3:0]       wstrb, osc_div, st, c;
   logic [1:0]       resp;
   wire logic        awready, wready, bvalid, arready, rvalid, irq, sys_reset_req;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   int               miscompares, checks_done, evts, i;

   watchdog_with_reset_flags #(.base_ticks(4)) i_watchdog_with_reset_flags (
      .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .wdt_osc(wdt_osc),
      .always_on_fuse(always_on_fuse), .brownout_reset(brownout_reset), .pin_reset(pin_reset),
      .dog_restart(dog_restart), .cpu_irq_enable(cpu_irq_enable), .irq_ack(irq_ack),
      .irq(irq), .sys_reset_req(sys_reset_req));

   ////////////////////////////////////////////////////////////////
   // Clock, slow oscillator, event count
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      osc_div <= osc_div + 4'h1;
      wdt_osc <= osc_div[3];
      if (irq || sys_reset_req) evts = evts + 1;
   end

   ////////////////////////////////////////////////////////////////
   // Expectation helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] psc_bits(input logic [3:0] k);
      return {2'b00, k[3], 2'b00, k[2:0]};
   endfunction

   function automatic logic [3:0] flags_after(input logic [3:0] old, input logic [3:0] d);
      return old & d;
   endfunction

   ////////////////////////////////////////////////////////////////
   // Checking and bus tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d, miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int   k;
      logic aw_hs, w_hs, done;
      done    = 1'b0;
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= 4'h1;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      // Outputs looked at mid-cycle, where they are settled
      for (k = 0; k < 50 && !done; k++) begin
         @(negedge clk);
         aw_hs = awvalid && (awready === 1'b1);
         w_hs  = wvalid && (wready === 1'b1);
         done  = (bvalid === 1'b1);
         resp  = bresp;
         @(posedge clk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
      end
      if (!done) miscompares++;
   endtask

   task automatic rd(input logic [7:0] a);
      int   k;
      logic ar_hs, done;
      done    = 1'b0;
      araddr  <= a;
      arvalid <= 1'b1;
      for (k = 0; k < 50 && !done; k++) begin
         @(negedge clk);
         ar_hs = arvalid && (arready === 1'b1);
         done  = (rvalid === 1'b1);
         rdv   = rdata;
         resp  = rresp;
         @(posedge clk);
         if (ar_hs) arvalid <= 1'b0;
      end
      if (!done) miscompares++;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(rdv, {24'h0, e});
   endtask

   task automatic restart;
      dog_restart <= 1'b1;
      @(posedge clk);
      dog_restart <= 1'b0;
   endtask

   task automatic wait_evt(input logic rst);
      int   k;
      logic hit;
      hit = 1'b0;
      for (k = 0; k < 4000 && !hit; k++) begin
         @(negedge clk);
         hit = ((rst ? sys_reset_req : irq) === 1'b1);
         @(posedge clk);
      end
      chk({31'h0, hit}, 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      resetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1; arvalid = 1'b0; rready = 1'b1;
      wdt_osc = 1'b0; osc_div = 4'h0; always_on_fuse = 1'b1; brownout_reset = 1'b0; pin_reset = 1'b0;
      dog_restart = 1'b0; cpu_irq_enable = 1'b0; irq_ack = 1'b0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0; wstrb = 4'h0; seed = 32'h84a36c8e; miscompares = 0; checks_done = 0; evts = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      rdc(CTRL_OFFSET, CTRL_RESET);
      rdc(STATUS_OFFSET, 8'h01);
      wr(8'h70, 8'hff);
      chk({30'h0, resp}, {30'h0, RESP_DECERR});
      rd(8'h70);
      chk(rdv, 32'h0);
      chk({30'h0, resp}, {30'h0, RESP_DECERR});
      $display("test reset values done");
      st = 4'h1;
      for (i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         if (seed[0]) pin_reset <= 1'b1;
         if (seed[1]) brownout_reset <= 1'b1;
         repeat (4) @(posedge clk);
         pin_reset <= 1'b0;
         brownout_reset <= 1'b0;
         repeat (4) @(posedge clk);
         st = st | {1'b0, seed[1], seed[0], 1'b0};
         rdc(STATUS_OFFSET, {4'h0, st});
         wr(STATUS_OFFSET, seed[15:8]);
         st = flags_after(st, seed[11:8]);
         rdc(STATUS_OFFSET, {4'h0, st});
      end
      wr(STATUS_OFFSET, 8'h00);
      $display("test status flags done");
      c = 4'h0;
      for (i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         wr(CTRL_OFFSET, seed[7:0] & 8'h27);
         rdc(CTRL_OFFSET, psc_bits(c));
         c = seed[19:16] % 4'ha;
         wr(CTRL_OFFSET, 8'h18);
         wr(CTRL_OFFSET, psc_bits(c));
         rdc(CTRL_OFFSET, psc_bits(c));
      end
      wr(CTRL_OFFSET, 8'h18);
      repeat (6) @(posedge clk);
      wr(CTRL_OFFSET, 8'h00);
      rdc(CTRL_OFFSET, 8'h08 | psc_bits(c));
      wr(CTRL_OFFSET, 8'h18);
      wr(CTRL_OFFSET, 8'h00);
      rdc(CTRL_OFFSET, 8'h00);
      $display("test protected changes done");
      cpu_irq_enable <= 1'b1;
      wr(CTRL_OFFSET, 8'h40);
      wait_evt(1'b0);
      rdc(CTRL_OFFSET, 8'hc0);
      wr(CTRL_OFFSET, 8'hc0);
      rdc(CTRL_OFFSET, 8'h40);
      cpu_irq_enable <= 1'b0;
      repeat (300) @(posedge clk);
      chk(irq, 1'b0);
      rdc(CTRL_OFFSET, 8'hc0);
      cpu_irq_enable <= 1'b1;
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      restart;
      wr(CTRL_OFFSET, 8'h80);
      rdc(CTRL_OFFSET, 8'h00);
      $display("test interrupt mode done");
      restart;
      wr(CTRL_OFFSET, 8'h48);
      wait_evt(1'b0);
      irq_ack <= 1'b1;
      @(posedge clk);
      irq_ack <= 1'b0;
      rdc(CTRL_OFFSET, 8'h08);
      wait_evt(1'b1);
      wr(CTRL_OFFSET, 8'h48);
      wait_evt(1'b0);
      wait_evt(1'b1);
      @(negedge clk);
      chk({31'h0, sys_reset_req}, 32'h0);
      @(posedge clk);
      rdc(STATUS_OFFSET, 8'h08);
      rdc(CTRL_OFFSET, 8'h08);
      restart;
      wr(CTRL_OFFSET, 8'h18);
      wr(CTRL_OFFSET, 8'h00);
      rdc(CTRL_OFFSET, 8'h08);
      wr(STATUS_OFFSET, 8'h00);
      restart;
      wr(CTRL_OFFSET, 8'h18);
      wr(CTRL_OFFSET, 8'h00);
      rdc(CTRL_OFFSET, 8'h00);
      rdc(STATUS_OFFSET, 8'h00);
      $display("test combined mode done");
      wr(CTRL_OFFSET, 8'h08);
      evts = 0;
      for (i = 0; i < 20; i++) begin
         restart;
         repeat (30) @(posedge clk);
      end
      chk(evts, 0);
      restart;
      wr(CTRL_OFFSET, 8'h18);
      wr(CTRL_OFFSET, 8'h00);
      evts = 0;
      repeat (500) @(posedge clk);
      chk(evts, 0);
      $display("test restart and stop done");
      always_on_fuse <= 1'b0;
      repeat (4) @(posedge clk);
      wr(CTRL_OFFSET, 8'h40);
      rdc(CTRL_OFFSET, 8'h08);
      wait_evt(1'b1);
      $display("test fuse done");
      results;
   end

   initial begin
      #800000;
      miscompares++;
      results;
   end
endmodule // tb
